// *** src/rlm_pkg.sv ***
// Purpose: Shared constants for the reference clock lock and rate meter.
// Assumes: 40 MHz core clock, 8-bit register link between the two ends.
// Notes: Register subaddresses and host bus offsets are fixed here.
package rlm_pkg;
  // Device register subaddresses
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_MISC = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CNT_MID = 3'h4;
  localparam logic [2:0] ADDR_CNT_LO = 3'h5;
  // Control fields of ref_clock_control
  localparam int BIT_LTR_EN = 0;
  localparam int BIT_RATE_EN = 1;
  localparam int RATIO_LSB = 2;
  localparam int RANGE_LSB = 6;
  // Second control register and misc status fields
  localparam int BIT_MEAS_START = 3;
  localparam int BIT_ACQ_START = 5;
  localparam int BIT_MISC_LOL = 0;
  localparam int BIT_MISC_DONE = 2;
  localparam int BIT_MISC_LOL_SEEN = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Measurement scale and ratio limit
  localparam int SCALE_BASE = 14;
  localparam logic [3:0] RATIO_MAX_CODE = 4'h8;
  localparam int COUNT_W = 23;
  // Host AHB-Lite offsets
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_IRQ_STAT = 8'h08;
  localparam logic [7:0] HOST_IRQ_MASK = 8'h0c;
  // Host command operations
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_ACQ = 2'h2;
  localparam logic [1:0] OP_MEAS = 2'h3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SEND = 3'b010,
    HS_WAIT = 3'b100
  } rlm_hstate_t;
endpackage

// *** src/rlm_if.sv ***
// Purpose: Register link between host controller and rate meter device.
// Assumes: Both ends run on the same core clock.
// Notes: Strobes are one-cycle pulses; ack answers one cycle later.
`timescale 1ns/1ps
interface rlm_if;
  logic regWr;
  logic regRd;
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regAck;
  modport dev (
    input regWr,
    input regRd,
    input regAddr,
    input regWdata,
    output regRdata,
    output regAck
  );
  modport host (
    output regWr,
    output regRd,
    output regAddr,
    output regWdata,
    input regRdata,
    input regAck
  );
endinterface

// *** src/rlm_device.sv ***
// Purpose: Reference clock lock control and fine data rate meter.
// Assumes: Reference and data clocks are slow enough to sample at 40 MHz.
// Notes: Count = data edges seen over 2^(14+range) reference edges.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module rlm_device (
  input wire logic core_clk,
  input wire logic rstn,
  rlm_if.dev link,
  input wire logic refClkPin,
  input wire logic dataClkPin,
  input wire logic lossOfLockPin,
  output logic lockToRefMode,
  output logic [1:0] refRange,
  output logic [8:0] lockMultiplier,
  output logic acqStart
);
  logic [7:0] ref_clock_control;
  logic [7:0] second_control_register;
  logic [2:0] refSync;
  logic [2:0] dataSync;
  logic [2:0] lolSync;
  logic refRise;
  logic dataRise;
  logic lolRise;
  logic measActive;
  logic measDone;
  logic lolSeen;
  logic gateOpen;
  logic gateEnd;
  logic [17:0] refCnt;
  logic [17:0] refTarget;
  logic [22:0] dataCnt;
  logic [22:0] rateCount;
  logic wrA;
  logic wrB;
  logic measKick;
  logic measClear;
  logic acqKick;
  logic [7:0] next_rdata;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      refSync <= 3'h0;
      dataSync <= 3'h0;
      lolSync <= 3'h0;
    end else begin
      refSync <= {refSync[1:0], refClkPin};
      dataSync <= {dataSync[1:0], dataClkPin};
      lolSync <= {lolSync[1:0], lossOfLockPin};
    end
  end

  // Edges taken between stages 1 and 2 only
  assign refRise = refSync[1] & ~refSync[2];
  assign dataRise = dataSync[1] & ~dataSync[2];
  assign lolRise = lolSync[1] & ~lolSync[2];

  //////////////////////////////////////////////////////////////////////
  // Register writes and their side effects
  assign wrA = link.regWr && (link.regAddr == rlm_pkg::ADDR_CTRL_A);
  assign wrB = link.regWr && (link.regAddr == rlm_pkg::ADDR_CTRL_B);
  // Falling edge of the start bit launches a run
  assign measKick = wrB && second_control_register[rlm_pkg::BIT_MEAS_START] &&
    !link.regWdata[rlm_pkg::BIT_MEAS_START] &&
    ref_clock_control[rlm_pkg::BIT_RATE_EN];
  // Writing the one already drops done
  assign measClear = wrB && link.regWdata[rlm_pkg::BIT_MEAS_START];
  // Three ways into a new acquisition, all only in lock mode
  assign acqKick = (wrB && second_control_register[rlm_pkg::BIT_ACQ_START] &&
      !link.regWdata[rlm_pkg::BIT_ACQ_START] &&
      ref_clock_control[rlm_pkg::BIT_LTR_EN]) ||
    (wrA && !ref_clock_control[rlm_pkg::BIT_LTR_EN] &&
      link.regWdata[rlm_pkg::BIT_LTR_EN]) ||
    (ref_clock_control[rlm_pkg::BIT_LTR_EN] && lolRise);

  // Control registers hold what the host last wrote
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_clock_control <= rlm_pkg::CTRL_RESET;
      second_control_register <= rlm_pkg::CTRL_RESET;
    end else begin
      if (wrA) begin
        ref_clock_control <= link.regWdata;
      end
      if (wrB) begin
        second_control_register <= link.regWdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Lock-to-reference outputs; they follow ref_clock_control in rate meter mode too
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lockToRefMode <= 1'b0;
      refRange <= 2'h0;
      lockMultiplier <= 9'h001;
      acqStart <= 1'b0;
    end else begin
      lockToRefMode <= ref_clock_control[rlm_pkg::BIT_LTR_EN];
      refRange <= ref_clock_control[rlm_pkg::RANGE_LSB +: 2];
      // Codes past 8 clamp to 256 rather than wrap
      if (ref_clock_control[rlm_pkg::RATIO_LSB +: 4] > rlm_pkg::RATIO_MAX_CODE) begin
        lockMultiplier <= 9'h100;
      end else begin
        lockMultiplier <= 9'(9'h001 << ref_clock_control[rlm_pkg::RATIO_LSB +: 4]);
      end
      acqStart <= acqKick;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Rate meter: gate length in reference edges follows the range field
  assign refTarget = 18'(18'h1 << (rlm_pkg::SCALE_BASE +
    int'(ref_clock_control[rlm_pkg::RANGE_LSB +: 2])));

  // Gate closes on the edge that ends 2^(14+range) whole periods
  assign gateEnd = measActive && gateOpen && refRise &&
    (refCnt == 18'(refTarget - 18'h1));

  // Run control and done flag; a finishing run wins over a clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      measActive <= 1'b0;
      measDone <= 1'b0;
    end else begin
      if (gateEnd) begin
        measActive <= 1'b0;
        measDone <= 1'b1;
      end else if (measKick) begin
        measActive <= 1'b1;
        measDone <= 1'b0;
      end else if (measClear) begin
        measDone <= 1'b0;
      end else if (!ref_clock_control[rlm_pkg::BIT_RATE_EN]) begin
        measActive <= 1'b0;
      end
    end
  end

  // Gate opens on a reference edge; a start mid-period would cut it short
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gateOpen <= 1'b0;
    end else if (measKick) begin
      gateOpen <= 1'b0;
    end else if (measActive && refRise) begin
      gateOpen <= 1'b1;
    end
  end

  // Gate and data counters; data count saturates instead of wrapping
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      refCnt <= 18'h0;
      dataCnt <= 23'h0;
    end else if (measKick) begin
      refCnt <= 18'h0;
      dataCnt <= 23'h0;
    end else if (measActive && gateOpen) begin
      if (refRise) begin
        refCnt <= refCnt + 18'h1;
      end
      if (dataRise && (dataCnt != 23'h7fffff)) begin
        dataCnt <= dataCnt + 23'h1;
      end
    end
  end

  // Result latched at the end of the gate and held until the next gate ends
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rateCount <= 23'h0;
    end else if (gateEnd) begin
      rateCount <= dataRise ? 23'(dataCnt + 23'h1) : dataCnt;
    end
  end

  // Lock loss during a run marks the result suspect
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lolSeen <= 1'b0;
    end else if (measActive && lolSync[2]) begin
      lolSeen <= 1'b1;
    end else if (measKick) begin
      lolSeen <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux; unknown subaddresses read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (link.regAddr)
      rlm_pkg::ADDR_CTRL_A: next_rdata = ref_clock_control;
      rlm_pkg::ADDR_CTRL_B: next_rdata = second_control_register;
      rlm_pkg::ADDR_MISC: begin
        next_rdata[rlm_pkg::BIT_MISC_LOL] = lolSync[2];
        next_rdata[rlm_pkg::BIT_MISC_DONE] = measDone;
        next_rdata[rlm_pkg::BIT_MISC_LOL_SEEN] = lolSeen;
      end
      rlm_pkg::ADDR_CNT_HI: next_rdata = {1'b0, rateCount[22:16]};
      rlm_pkg::ADDR_CNT_MID: next_rdata = rateCount[15:8];
      rlm_pkg::ADDR_CNT_LO: next_rdata = rateCount[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  // Ack one cycle after each strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      link.regRdata <= 8'h00;
      link.regAck <= 1'b0;
    end else begin
      link.regAck <= link.regWr | link.regRd;
      if (link.regRd) begin
        link.regRdata <= next_rdata;
      end
    end
  end
endmodule

// *** src/rlm_host.sv ***
// Purpose: Host controller driving the rate meter register link.
// Assumes: Software issues commands over AHB-Lite, one at a time.
// Notes: Start pulses are expanded into a one-then-zero write pair.
`timescale 1ns/1ps
module rlm_host (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  rlm_if.host link
);
  rlm_pkg::rlm_hstate_t state;
  logic apWr;
  logic [7:0] apAddr;
  logic [7:0] shadowA;
  logic [7:0] shadowB;
  logic [7:0] lastRead;
  logic needClear;
  logic needAcq;
  logic refused;
  logic [1:0] irqStat;
  logic [1:0] irqMask;
  logic cmdGo;
  logic [1:0] cmdOp;
  logic [2:0] cmdAddr;
  logic [7:0] cmdData;
  logic xferDone;

  //////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      apWr <= 1'b0;
      apAddr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      apWr <= hsel && htrans[1] && hwrite;
      apAddr <= haddr[7:0];
    end
  end

  // Read data driven in the data phase; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        rlm_pkg::HOST_STATUS:
          hrdata <= {16'h0, lastRead, 6'h0, refused,
            state != rlm_pkg::HS_IDLE};
        rlm_pkg::HOST_IRQ_STAT: hrdata <= {30'h0, irqStat};
        rlm_pkg::HOST_IRQ_MASK: hrdata <= {30'h0, irqMask};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Command decode; new commands while busy are dropped
  assign cmdGo = apWr && (apAddr == rlm_pkg::HOST_CMD) &&
    (state == rlm_pkg::HS_IDLE);
  assign cmdOp = hwdata[13:12];
  assign cmdAddr = hwdata[10:8];
  assign cmdData = hwdata[7:0];
  assign xferDone = (state == rlm_pkg::HS_WAIT) && link.regAck &&
    !needClear && !needAcq;

  //////////////////////////////////////////////////////////////////////
  // Link sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= rlm_pkg::HS_IDLE;
      link.regWr <= 1'b0;
      link.regRd <= 1'b0;
      link.regAddr <= 3'h0;
      link.regWdata <= 8'h00;
      shadowA <= rlm_pkg::CTRL_RESET;
      shadowB <= rlm_pkg::CTRL_RESET;
      needClear <= 1'b0;
      needAcq <= 1'b0;
      refused <= 1'b0;
      lastRead <= 8'h00;
    end else begin
      link.regWr <= 1'b0;
      link.regRd <= 1'b0;
      unique case (state)
        rlm_pkg::HS_IDLE: begin
          if (cmdGo) begin
            refused <= 1'b0;
            state <= rlm_pkg::HS_SEND;
            link.regAddr <= cmdAddr;
            link.regWdata <= cmdData;
            if (cmdOp == rlm_pkg::OP_READ) begin
              link.regRd <= 1'b1;
            end else if (cmdOp == rlm_pkg::OP_WRITE) begin
              // Both enables together is never sent
              if (cmdAddr == rlm_pkg::ADDR_CTRL_A &&
                  cmdData[rlm_pkg::BIT_LTR_EN] &&
                  cmdData[rlm_pkg::BIT_RATE_EN]) begin
                refused <= 1'b1;
                state <= rlm_pkg::HS_IDLE;
              end else begin
                link.regWr <= 1'b1;
                if (cmdAddr == rlm_pkg::ADDR_CTRL_A) begin
                  shadowA <= cmdData;
                  // Field change in lock mode forces reacquisition
                  needAcq <= cmdData[rlm_pkg::BIT_LTR_EN] &&
                    shadowA[rlm_pkg::BIT_LTR_EN] &&
                    (cmdData[7:2] != shadowA[7:2]);
                end
                if (cmdAddr == rlm_pkg::ADDR_CTRL_B) begin
                  shadowB <= cmdData;
                end
              end
            end else begin
              // Start pulse: write the one, clear it next
              link.regWr <= 1'b1;
              link.regAddr <= rlm_pkg::ADDR_CTRL_B;
              link.regWdata <= shadowB | ((cmdOp == rlm_pkg::OP_ACQ) ?
                (8'h01 << rlm_pkg::BIT_ACQ_START) :
                (8'h01 << rlm_pkg::BIT_MEAS_START));
              needClear <= 1'b1;
            end
          end
        end
        rlm_pkg::HS_SEND: state <= rlm_pkg::HS_WAIT;
        rlm_pkg::HS_WAIT: begin
          if (link.regAck) begin
            if (needClear) begin
              link.regWr <= 1'b1;
              link.regAddr <= rlm_pkg::ADDR_CTRL_B;
              link.regWdata <= shadowB;
              needClear <= 1'b0;
              state <= rlm_pkg::HS_SEND;
            end else if (needAcq) begin
              link.regWr <= 1'b1;
              link.regAddr <= rlm_pkg::ADDR_CTRL_B;
              link.regWdata <= shadowB |
                (8'h01 << rlm_pkg::BIT_ACQ_START);
              needAcq <= 1'b0;
              needClear <= 1'b1;
              state <= rlm_pkg::HS_SEND;
            end else begin
              lastRead <= link.regRdata;
              state <= rlm_pkg::HS_IDLE;
            end
          end
        end
        default: state <= rlm_pkg::HS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear; set wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqStat <= 2'h0;
      irqMask <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (apWr && apAddr == rlm_pkg::HOST_IRQ_MASK) begin
        irqMask <= hwdata[1:0];
      end
      irqStat[rlm_pkg::IRQ_DONE] <= xferDone ||
        (irqStat[rlm_pkg::IRQ_DONE] && !(apWr &&
        apAddr == rlm_pkg::HOST_IRQ_STAT && hwdata[rlm_pkg::IRQ_DONE]));
      irqStat[rlm_pkg::IRQ_REFUSED] <= (cmdGo &&
        cmdOp == rlm_pkg::OP_WRITE && cmdAddr == rlm_pkg::ADDR_CTRL_A &&
        cmdData[1:0] == 2'h3) || (irqStat[rlm_pkg::IRQ_REFUSED] &&
        !(apWr && apAddr == rlm_pkg::HOST_IRQ_STAT &&
        hwdata[rlm_pkg::IRQ_REFUSED]));
      irq <= |(irqStat & irqMask);
    end
  end
endmodule

// *** dv/rlm_assertions.sv ***
// Purpose: Link protocol checks between rate meter host and device.
// Assumes: One core clock, asynchronous active low reset.
// Notes: Watches only the link signals of the shared interface.
`timescale 1ns/1ps
module rlm_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regAck
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // Strobes are single pulses answered exactly one cycle later
  a_ack_one_late:
    assert property ((regWr || regRd) |=> regAck && !regWr && !regRd)
    else $error("link strobe not answered next cycle");
  a_no_stray_ack:
    assert property (regAck |-> $past(regWr || regRd))
    else $error("link ack without strobe");
  a_single_strobe:
    assert property (!(regWr && regRd))
    else $error("read and write strobed together");
  // Both enables together would leave the device undefined
  a_no_dual_enable:
    assert property (regWr && regAddr == rlm_pkg::ADDR_CTRL_A
      |-> !(regWdata[0] && regWdata[1]))
    else $error("both mode enables written");
  // A start bit raised must be dropped again soon after
  a_meas_pulse_pair:
    assert property (regWr && regAddr == rlm_pkg::ADDR_CTRL_B
      && regWdata[rlm_pkg::BIT_MEAS_START] |-> ##[1:4]
      (regWr && regAddr == rlm_pkg::ADDR_CTRL_B
      && !regWdata[rlm_pkg::BIT_MEAS_START]))
    else $error("measurement start not dropped");
  a_acq_pulse_pair:
    assert property (regWr && regAddr == rlm_pkg::ADDR_CTRL_B
      && regWdata[rlm_pkg::BIT_ACQ_START] |-> ##[1:4]
      (regWr && regAddr == rlm_pkg::ADDR_CTRL_B
      && !regWdata[rlm_pkg::BIT_ACQ_START]))
    else $error("acquisition start not dropped");
  a_count_hi_msb:
    assert property (regAck && $past(regRd)
      && $past(regAddr) == rlm_pkg::ADDR_CNT_HI |-> !regRdata[7])
    else $error("count high byte top bit set");
  // Read data may move only with the answer to a read
  a_rdata_hold:
    assert property ($changed(regRdata) |-> regAck && $past(regRd))
    else $error("read data changed without a read");
endmodule

// *** dv/tb_reference_clock_lock_and_rate_meter.sv ***
// Purpose: Self-checking bench for host and device over the link.
// Assumes: 40 MHz core clock, free running 200 ns reference clock.
// Notes: One full gate at range 00 takes about 131k core cycles.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h want %h", $time, a, e); end end
module tb_reference_clock_lock_and_rate_meter;
  localparam int REF_NS = 200;
  localparam int DATA_NS = 160;
  localparam int EXP_CNT = (1 << rlm_pkg::SCALE_BASE) * REF_NS / DATA_NS;
  localparam int LIMIT = 200000;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, lockToRefMode, acqStart;
  logic refClkPin = 1'b0;
  logic dataClkPin = 1'b0;
  logic lossOfLockPin = 1'b0;
  logic [1:0] refRange;
  logic [8:0] lockMultiplier;
  logic [31:0] st;
  logic [22:0] cnt;
  logic [7:0] rowCtrl [11] = '{8'h01, 8'h45, 8'h89, 8'hcd, 8'h11, 8'h55,
    8'h99, 8'hdd, 8'h21, 8'h65, 8'hbd};
  logic [8:0] rowMult [11] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010,
    9'h020, 9'h040, 9'h080, 9'h100, 9'h100, 9'h100};
  int n_mismatch = 0;
  int compares = 0;
  int acqCount = 0;
  int cyc = 0;
  int a0;
  ////////////////////////////////////////////////////////////
  // Clocks; reference and data clocks free run, off the core clock rising edges
  always #12.5 core_clk = ~core_clk;
  always #(REF_NS / 2) refClkPin = ~refClkPin;
  always #(DATA_NS / 2) dataClkPin = ~dataClkPin;
  rlm_if rlm_if_i();
  rlm_host rlm_host_i(.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(rlm_if_i));
  rlm_device rlm_device_i(.core_clk(core_clk), .rstn(rstn),
    .link(rlm_if_i), .refClkPin(refClkPin), .dataClkPin(dataClkPin),
    .lossOfLockPin(lossOfLockPin), .lockToRefMode(lockToRefMode),
    .refRange(refRange), .lockMultiplier(lockMultiplier),
    .acqStart(acqStart));
  rlm_assertions rlm_assertions_i(.core_clk(core_clk), .rstn(rstn),
    .regWr(rlm_if_i.regWr), .regRd(rlm_if_i.regRd),
    .regAddr(rlm_if_i.regAddr), .regWdata(rlm_if_i.regWdata),
    .regRdata(rlm_if_i.regRdata), .regAck(rlm_if_i.regAck));
  // Acquisition pulse count and hang guard
  always @(posedge core_clk) begin
    if (acqStart === 1'b1)
      acqCount++;
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One single word transfer; read data lands in st
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    st = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  // Command then poll busy; the last read byte sits in st[15:8]
  task automatic cmd(input logic [1:0] op, input logic [2:0] sub,
    input logic [7:0] d);
    ahb(1'b1, rlm_pkg::HOST_CMD, {18'h0, op, 1'b0, sub, d});
    do ahb(1'b0, rlm_pkg::HOST_STATUS, 32'h0); while (st[0] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    // Ratio codes 0 to 9 and 15 with a rotating range, lock mode held on
    for (int i = 0; i < 11; i++) begin
      a0 = acqCount;
      cmd(rlm_pkg::OP_WRITE, rlm_pkg::ADDR_CTRL_A, rowCtrl[i]);
      `CHK(lockMultiplier, rowMult[i])
      `CHK(refRange, rowCtrl[i][7:6])
      `CHK(lockToRefMode, 1'b1)
      `CHK(acqCount - a0, 1)
      cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_CTRL_A, 8'h0);
      `CHK(st[15:8], rowCtrl[i])
    end
    // Explicit start, then lost lock, each retrigger once
    a0 = acqCount;
    cmd(rlm_pkg::OP_ACQ, rlm_pkg::ADDR_CTRL_B, 8'h0);
    `CHK(acqCount - a0, 1)
    lossOfLockPin <= 1'b1;
    repeat (10) @(posedge core_clk);
    `CHK(acqCount - a0, 2)
    lossOfLockPin <= 1'b0;
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(st, 32'h0)
    cmd(rlm_pkg::OP_READ, 3'h7, 8'h0);
    `CHK(st[15:8], 8'h0)
    // Interrupt raised, cleared, masked; dual enable refused
    ahb(1'b1, rlm_pkg::HOST_IRQ_MASK, 32'h1);
    repeat (3) @(posedge core_clk);
    `CHK(irq, 1'b1)
    ahb(1'b1, rlm_pkg::HOST_IRQ_STAT, 32'h3);
    repeat (3) @(posedge core_clk);
    `CHK(irq, 1'b0)
    ahb(1'b1, rlm_pkg::HOST_IRQ_MASK, 32'h0);
    cmd(rlm_pkg::OP_WRITE, rlm_pkg::ADDR_CTRL_A, 8'h03);
    `CHK(st[1], 1'b1)
    `CHK(irq, 1'b0)
    `CHK(lockToRefMode, 1'b1)
    ahb(1'b0, rlm_pkg::HOST_IRQ_STAT, 32'h0);
    `CHK(st[1:0], 2'h2)
    ahb(1'b1, rlm_pkg::HOST_IRQ_MASK, 32'h2);
    repeat (3) @(posedge core_clk);
    `CHK(irq, 1'b1)
    ahb(1'b0, rlm_pkg::HOST_IRQ_MASK, 32'h0);
    `CHK(st, 32'h2)
    ahb(1'b1, rlm_pkg::HOST_IRQ_STAT, 32'h2);
    repeat (3) @(posedge core_clk);
    `CHK(irq, 1'b0)
    // Rate readback at range 00; lock glitch mid-gate
    a0 = acqCount;
    cmd(rlm_pkg::OP_WRITE, rlm_pkg::ADDR_CTRL_A, 8'h02);
    `CHK(lockToRefMode, 1'b0)
    cmd(rlm_pkg::OP_MEAS, rlm_pkg::ADDR_CTRL_B, 8'h0);
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_MISC, 8'h0);
    `CHK(st[8 + rlm_pkg::BIT_MISC_DONE], 1'b0)
    lossOfLockPin <= 1'b1;
    repeat (10) @(posedge core_clk);
    lossOfLockPin <= 1'b0;
    do begin
      repeat (2000) @(posedge core_clk);
      cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_MISC, 8'h0);
    end while (st[8 + rlm_pkg::BIT_MISC_DONE] !== 1'b1);
    `CHK(st[8 + rlm_pkg::BIT_MISC_LOL_SEEN], 1'b1)
    `CHK(st[8 + rlm_pkg::BIT_MISC_LOL], 1'b0)
    `CHK(acqCount - a0, 0)
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_CNT_HI, 8'h0);
    `CHK(st[15], 1'b0)
    cnt[22:16] = st[14:8];
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_CNT_MID, 8'h0);
    cnt[15:8] = st[15:8];
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_CNT_LO, 8'h0);
    cnt[7:0] = st[15:8];
    `CHK(cnt inside {[EXP_CNT - 1 : EXP_CNT + 1]}, 1'b1)
    // Result holds until the next start, which clears done
    repeat (1000) @(posedge core_clk);
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_CNT_LO, 8'h0);
    `CHK(st[15:8], cnt[7:0])
    cmd(rlm_pkg::OP_MEAS, rlm_pkg::ADDR_CTRL_B, 8'h0);
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_MISC, 8'h0);
    `CHK(st[8 + rlm_pkg::BIT_MISC_DONE], 1'b0)
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_CTRL_A, 8'h0);
    `CHK(st[15:8], 8'h02)
    // Reset while that run is under way
    rstn <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK({lockToRefMode, refRange, lockMultiplier, irq, hreadyout},
      14'h0005)
    rstn <= 1'b1;
    cmd(rlm_pkg::OP_READ, rlm_pkg::ADDR_CTRL_A, 8'h0);
    `CHK(st[15:8], 8'h00)
    test_done();
  end
endmodule
